/* pmpc_mem_model.sv */
// far-side memory model: keeps line data and answers reads, with an optional single-bit fault
`timescale 1ns/1ps
module pmpc_mem_model (
	input wire logic clk_in,
	input wire pmpc_pkg::pmpc_access_s wr_in,
	input wire logic [pmpc_pkg::DATA_W-1:0] wr_data_in,
	input wire pmpc_pkg::pmpc_access_s rd_in,
	input wire logic flip_in,
	output logic [pmpc_pkg::DATA_W-1:0] rd_data_out
);
	import pmpc_pkg::*;
	logic [DATA_W-1:0] mem_q [4];
	logic [DATA_W-1:0] last_q = '0;
	always_ff @(posedge clk_in) begin
		if (wr_in.valid) begin
			mem_q[wr_in.addr[6:5]] <= wr_data_in;
		end
		if (rd_in.valid) begin
			last_q <= ~rd_data_out;
		end
	end
	// idle data lines show the inverse of the last value, never a stale copy
	always_comb begin
		if (rd_in.valid) begin
			rd_data_out = mem_q[rd_in.addr[6:5]] ^ {{(DATA_W-1){1'b0}}, flip_in};
		end else begin
			rd_data_out = last_q;
		end
	end
endmodule : pmpc_mem_model

/* pmpc_parity_chk.sv */
// parity of one 256-bit line and comparison with the stored bit
`timescale 1ns/1ps
module pmpc_parity_chk (
	input wire logic [pmpc_pkg::DATA_W-1:0] data_in,
	input wire logic stored_par_in,
	input wire logic stored_val_in,
	output logic par_out,
	output logic err_out
);
	import pmpc_pkg::*;

	assign par_out = ^data_in; // R20
	assign err_out = stored_val_in && (par_out != stored_par_in); // R23
endmodule : pmpc_parity_chk

/* pmpc_pkg.sv */
// constants, types and register map for the program memory parity checker
// How it works
// R1 - command bits act only when written one; zeros change nothing
// R2 - command bit 6 clears remote read error, bit 5 clears fetch error
// R3 - bit 3 suspends, bit 2 disables, bit 0 enables; other bits reserved
// R4 - two or more mode bits in one write force disabled mode
// R5 - one write may clear both errors and change mode together
// R6 - location holds address bits 31-5; bits 4-1 read zero
// R7 - location bit 0 is one for program RAM, zero for cache
// R8 - reset enters disabled: writes clear valid, reads unchecked
// R9 - enabling never initialises parity storage; software writes RAM first
// R10 - enabled: full writes store parity and set valid; full reads checked
// R11 - suspended: no checks, stored parity and valid untouched
// R12 - disable accepted anytime; valid cleared per write, never in bulk
// R13 - two error outputs: fetch exception and remote parity event
// R14 - fetch error asserted one to two cycles after the fetch
// R15 - remote error appears as interrupt controller event 113
// R16 - only first error recorded; later reports suppressed until cleared
// R17 - fetch error overrides a recorded remote error and raises exception
// R18 - debug emulation reads are never checked
// R19 - debug emulation writes clear valid except while suspended
// R20 - parity is the xor of all 256 data bits versus stored bit
// R21 - narrow writes mark stored parity invalid
// R22 - status shows one mode flag and at most one error flag, read only
// R23 - error only when valid set and computed parity differs
package pmpc_pkg;
	localparam int unsigned DATA_W = 256;
	localparam int unsigned IDX_W = 10;
	localparam int unsigned DEPTH = 1024;
	localparam int unsigned LINE_LSB = 5;
	localparam int unsigned ADDR_W = 32;

	localparam logic [31:0] STATUS_ADDR = 32'h0184_6404;
	localparam logic [31:0] CMD_ADDR = 32'h0184_6408;
	localparam logic [31:0] LOC_ADDR = 32'h0184_640C;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// command and status share these bit positions
	localparam int unsigned BIT_EN = 0;
	localparam int unsigned BIT_DIS = 2;
	localparam int unsigned BIT_HALT_CHECKING_COMMAND = 3;
	localparam int unsigned BIT_FETCH_ERR = 5;
	localparam int unsigned BIT_REMOTE_ERR = 6;
	localparam int unsigned LOC_RAM_BIT = 0;
	localparam logic [3:0] LOC_RSVD = 4'h0;

	localparam logic [2:0] MB_NONE = 3'h0;
	localparam logic [2:0] MB_EN = 3'h1;
	localparam logic [2:0] MB_DIS = 3'h2;
	localparam logic [2:0] MB_HALT_CHECKING_COMMAND = 3'h4;

	localparam logic [7:0] REMOTE_EVENT_NUM = 8'h71;

	typedef enum logic [1:0] {
		MODE_DIS = 2'b00,
		MODE_EN = 2'b01,
		MODE_HALT_CHECKING_COMMAND = 2'b10
	} pmpc_mode_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pmpc_reg_req_s;

	// one memory access; fetch is ignored on the write channel
	typedef struct packed {
		logic valid;
		logic full;
		logic emu;
		logic fetch;
		logic ram;
		logic [ADDR_W-1:0] addr;
	} pmpc_access_s;
endpackage : pmpc_pkg

/* pmpc_top.sv */
// program memory parity checker: storage, mode control, error record, registers
`timescale 1ns/1ps
module pmpc_top (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire pmpc_pkg::pmpc_reg_req_s reg_req_in,
	output logic [31:0] reg_rdata_out,
	input wire pmpc_pkg::pmpc_access_s mem_wr_in,
	input wire logic [pmpc_pkg::DATA_W-1:0] mem_wr_data_in,
	input wire pmpc_pkg::pmpc_access_s mem_rd_in,
	input wire logic [pmpc_pkg::DATA_W-1:0] mem_rd_data_in,
	output logic fetch_exception_out,
	output logic remote_parity_event_out,
	output logic [7:0] remote_event_id_out
);
	import pmpc_pkg::*;

	pmpc_mode_e mode_q;
	pmpc_mode_e mode_d;
	logic fetch_err_q;
	logic fetch_err_d;
	logic remote_err_q;
	logic remote_err_d;
	logic [31:0] loc_q;
	logic [31:0] loc_d;
	logic fetch_exc_q;
	logic remote_evt_q;
	logic [31:0] rdata_q;
	logic [7:0] event_id_q;

	// per-line parity and valid, deliberately without reset
	logic stored_par [DEPTH];
	logic stored_val [DEPTH];

	logic cmd_wr;
	logic [2:0] mode_bits;
	logic fetch_clr;
	logic remote_clr;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic wr_par;
	logic rd_par;
	logic rd_mismatch;
	logic chk_on;
	logic fetch_err_now;
	logic remote_err_now;
	logic fetch_held;
	logic remote_held;
	logic take_fetch;
	logic take_remote;
	logic [31:0] status_word;

	assign cmd_wr = reg_req_in.wr && (reg_req_in.addr == CMD_ADDR);
	assign mode_bits = {reg_req_in.wdata[BIT_HALT_CHECKING_COMMAND], reg_req_in.wdata[BIT_DIS], reg_req_in.wdata[BIT_EN]};
	assign fetch_clr = cmd_wr && reg_req_in.wdata[BIT_FETCH_ERR]; // R2 R1
	assign remote_clr = cmd_wr && reg_req_in.wdata[BIT_REMOTE_ERR]; // R2 R1

	assign wr_idx = mem_wr_in.addr[LINE_LSB +: IDX_W];
	assign rd_idx = mem_rd_in.addr[LINE_LSB +: IDX_W];

	pmpc_parity_chk u_wr_par (
		.data_in(mem_wr_data_in),
		.stored_par_in(1'b0),
		.stored_val_in(1'b0),
		.par_out(wr_par),
		.err_out()
	);

	pmpc_parity_chk u_rd_chk (
		.data_in(mem_rd_data_in),
		.stored_par_in(stored_par[rd_idx]),
		.stored_val_in(stored_val[rd_idx]),
		.par_out(rd_par),
		.err_out(rd_mismatch)
	);

	// mode command decode
	always_comb begin
		mode_d = mode_q;
		if (cmd_wr) begin
			case (mode_bits)
				MB_NONE: mode_d = mode_q; // R1
				MB_EN: mode_d = MODE_EN; // R3 R9
				MB_DIS: mode_d = MODE_DIS; // R3 R12
				MB_HALT_CHECKING_COMMAND: mode_d = MODE_HALT_CHECKING_COMMAND; // R3
				default: mode_d = MODE_DIS; // R4
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= MODE_DIS; // R8
		end else begin
			mode_q <= mode_d;
		end
	end

	// parity storage update; no bulk clear on any mode change
	always_ff @(posedge sys_clk_in) begin
		if (mem_wr_in.valid && (mode_q != MODE_HALT_CHECKING_COMMAND)) begin // R11 R19
			if ((mode_q == MODE_EN) && mem_wr_in.full && !mem_wr_in.emu) begin
				stored_par[wr_idx] <= wr_par; // R10
				stored_val[wr_idx] <= 1'b1; // R10
			end else begin
				stored_val[wr_idx] <= 1'b0; // R8 R12 R19 R21
			end
		end
	end

	// only full, non-debug reads in enabled mode are checked
	assign chk_on = mem_rd_in.valid && mem_rd_in.full && !mem_rd_in.emu && (mode_q == MODE_EN); // R10 R11 R18
	assign fetch_err_now = chk_on && rd_mismatch && mem_rd_in.fetch; // R13
	assign remote_err_now = chk_on && rd_mismatch && !mem_rd_in.fetch; // R13

	// clears act first so that an error in the same cycle is kept
	assign fetch_held = fetch_err_q && !fetch_clr;
	assign remote_held = remote_err_q && !remote_clr;
	assign take_fetch = fetch_err_now && !fetch_held; // R16 R17
	assign take_remote = remote_err_now && !fetch_held && !remote_held && !fetch_err_now; // R16

	always_comb begin
		fetch_err_d = fetch_held;
		remote_err_d = remote_held;
		loc_d = loc_q;
		if (take_fetch) begin
			fetch_err_d = 1'b1; // R17
			remote_err_d = 1'b0; // R17 R22
		end else if (take_remote) begin
			remote_err_d = 1'b1; // R16
		end
		if (take_fetch || take_remote) begin
			loc_d = {mem_rd_in.addr[ADDR_W-1:LINE_LSB], LOC_RSVD, mem_rd_in.ram}; // R6 R7
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fetch_err_q <= 1'b0;
			remote_err_q <= 1'b0;
			loc_q <= WORD_ZERO;
		end else begin
			fetch_err_q <= fetch_err_d; // R5
			remote_err_q <= remote_err_d; // R5
			loc_q <= loc_d;
		end
	end

	// error outputs, one cycle after the checked read
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fetch_exc_q <= 1'b0;
			remote_evt_q <= 1'b0;
			event_id_q <= REMOTE_EVENT_NUM;
		end else begin
			fetch_exc_q <= take_fetch; // R14
			remote_evt_q <= take_remote; // R13
			event_id_q <= REMOTE_EVENT_NUM; // R15
		end
	end

	always_comb begin
		status_word = WORD_ZERO;
		status_word[BIT_EN] = (mode_q == MODE_EN); // R22
		status_word[BIT_DIS] = (mode_q == MODE_DIS); // R22
		status_word[BIT_HALT_CHECKING_COMMAND] = (mode_q == MODE_HALT_CHECKING_COMMAND); // R22
		status_word[BIT_FETCH_ERR] = fetch_err_q;
		status_word[BIT_REMOTE_ERR] = remote_err_q;
	end

	// read data valid only in the cycle after the strobe; command reads zero
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= WORD_ZERO;
		end else if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				STATUS_ADDR: rdata_q <= status_word;
				LOC_ADDR: rdata_q <= loc_q;
				default: rdata_q <= WORD_ZERO;
			endcase
		end else begin
			rdata_q <= WORD_ZERO;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign fetch_exception_out = fetch_exc_q;
	assign remote_parity_event_out = remote_evt_q;
	assign remote_event_id_out = event_id_q;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_fetch_bad;
		mem_rd_in.valid && mem_rd_in.fetch && mem_rd_in.full && !mem_rd_in.emu && (mode_q == MODE_EN) && rd_mismatch;
	endsequence

	sequence s_remote_bad;
		mem_rd_in.valid && !mem_rd_in.fetch && mem_rd_in.full && !mem_rd_in.emu && (mode_q == MODE_EN) && rd_mismatch;
	endsequence

	a_reset_mode_dis: assert property ($past(rst_in) |-> mode_q == MODE_DIS) // R8
		else $error("mode not disabled after reset");

	a_zero_cmd_idle: assert property (cmd_wr && (mode_bits == MB_NONE) |=> mode_q == $past(mode_q)) // R1
		else $error("zero command bits changed the mode");

	a_multi_mode_dis: assert property (cmd_wr && ($countones(mode_bits) > 1) |=> mode_q == MODE_DIS) // R4
		else $error("several mode bits did not disable");

	a_mode_cmd_apply: assert property (cmd_wr && (mode_bits == MB_HALT_CHECKING_COMMAND) |=> mode_q == MODE_HALT_CHECKING_COMMAND) // R3
		else $error("suspend command not applied");

	a_fetch_clear: assert property (fetch_clr && !mem_rd_in.valid |=> !fetch_err_q) // R2
		else $error("fetch error flag not cleared");

	a_fetch_exc_time: assert property (s_fetch_bad ##0 !fetch_err_q |-> ##[1:2] fetch_exception_out) // R14
		else $error("fetch exception late or missing");

	a_fetch_override: assert property (s_fetch_bad ##0 (remote_err_q && !fetch_err_q) |=> fetch_err_q && !remote_err_q
		&& (loc_q[ADDR_W-1:LINE_LSB] == $past(mem_rd_in.addr[ADDR_W-1:LINE_LSB]))) // R17
		else $error("fetch error did not replace remote record");

	a_first_only: assert property (s_remote_bad ##0 (remote_err_q && !remote_clr) |=> !remote_parity_event_out) // R16
		else $error("second remote error reported");

	a_one_err_flag: assert property (!(fetch_err_q && remote_err_q)) // R22
		else $error("both error flags set");

	a_quiet_unchecked: assert property ((mode_q != MODE_EN) || (mem_rd_in.valid && mem_rd_in.emu)
		|=> !fetch_exception_out && !remote_parity_event_out) // R11 R18
		else $error("error reported for unchecked read");

	a_loc_layout: assert property (take_remote |=> (loc_q[4:1] == LOC_RSVD) && (loc_q[LOC_RAM_BIT] == $past(mem_rd_in.ram))) // R6 R7
		else $error("location register layout wrong");

	a_en_cmd_apply: assert property (cmd_wr && (mode_bits == MB_EN) |=> mode_q == MODE_EN) // R3
		else $error("enable command not applied");

	a_dis_cmd_apply: assert property (cmd_wr && (mode_bits == MB_DIS) |=> mode_q == MODE_DIS) // R3 R12
		else $error("disable command not applied");

	a_remote_clear: assert property (remote_clr && !mem_rd_in.valid |=> !remote_err_q) // R2
		else $error("remote error flag not cleared");

	a_both_clear: assert property (fetch_clr && remote_clr && !mem_rd_in.valid |=> !fetch_err_q && !remote_err_q) // R5
		else $error("combined clear did not clear both flags");

	a_remote_evt_time: assert property (s_remote_bad ##0 (!fetch_err_q && !remote_err_q) |=> remote_parity_event_out) // R13
		else $error("remote parity event missing");

	a_event_id_const: assert property (remote_event_id_out == REMOTE_EVENT_NUM) // R15
		else $error("remote event number wrong");

	a_rdata_idle: assert property (!reg_req_in.rd |=> reg_rdata_out == WORD_ZERO)
		else $error("read data not zero outside a read");

	a_status_read: assert property (reg_req_in.rd && (reg_req_in.addr == STATUS_ADDR) |=> reg_rdata_out == $past(status_word)) // R22
		else $error("status read returned wrong word");

	a_fetch_loc: assert property (take_fetch |=> (loc_q[4:1] == LOC_RSVD) && (loc_q[LOC_RAM_BIT] == $past(mem_rd_in.ram))) // R6 R7
		else $error("fetch location layout wrong");

	a_halt_checking_command_keeps_valid: assert property (mem_wr_in.valid && (mode_q == MODE_HALT_CHECKING_COMMAND)
		|=> stored_val[$past(wr_idx)] == $past(stored_val[wr_idx])) // R11
		else $error("suspended write changed a valid bit");

	a_en_write_valid: assert property (mem_wr_in.valid && mem_wr_in.full && !mem_wr_in.emu && (mode_q == MODE_EN)
		|=> stored_val[$past(wr_idx)]) // R10
		else $error("full write did not set valid");

	a_narrow_invalid: assert property (mem_wr_in.valid && !mem_wr_in.full && (mode_q != MODE_HALT_CHECKING_COMMAND)
		|=> !stored_val[$past(wr_idx)]) // R21
		else $error("narrow write left valid set");

	a_emu_invalid: assert property (mem_wr_in.valid && mem_wr_in.emu && (mode_q != MODE_HALT_CHECKING_COMMAND)
		|=> !stored_val[$past(wr_idx)]) // R19
		else $error("debug write left valid set");

	a_one_mode_flag: assert property ($onehot({status_word[BIT_EN], status_word[BIT_DIS], status_word[BIT_HALT_CHECKING_COMMAND]})) // R22
		else $error("mode flags not one-hot");

	a_invalid_quiet: assert property (chk_on && !stored_val[rd_idx]
		|=> !fetch_exception_out && !remote_parity_event_out) // R23
		else $error("error reported for invalid entry");
endmodule : pmpc_top

/* pmpc_top_tb.sv */
// self-checking testbench for the program memory parity checker
`timescale 1ns/1ps
module pmpc_top_tb;
	import pmpc_pkg::*;
	localparam logic [31:0] BASE = 32'h0020_0000;
	localparam logic [31:0] ST = STATUS_ADDR;
	localparam logic [31:0] CM = CMD_ADDR;
	localparam logic [31:0] LC = LOC_ADDR;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pmpc_reg_req_s rq = '0;
	pmpc_access_s wr = '0;
	pmpc_access_s rd = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] ln [4];
	logic flip = 1'b0;
	logic [31:0] reg_rdata;
	logic fexc;
	logic rev;
	logic [7:0] ev_id;
	logic [31:0] reg_q [$];
	logic [31:0] ev_q [$];
	logic rd_pend = 1'b0;
	logic mr_pend = 1'b0;
	int num_errors = 0;
	int n_tests = 0;
	int i;
	always #2.5 sys_clk = ~sys_clk;
	pmpc_top dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .reg_req_in(rq), .reg_rdata_out(reg_rdata),
		.mem_wr_in(wr), .mem_wr_data_in(wdata), .mem_rd_in(rd), .mem_rd_data_in(rdata),
		.fetch_exception_out(fexc), .remote_parity_event_out(rev), .remote_event_id_out(ev_id));
	pmpc_mem_model mdl_u (.clk_in(sys_clk), .wr_in(wr), .wr_data_in(wdata), .rd_in(rd), .flip_in(flip),
		.rd_data_out(rdata));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test();
		if (num_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	function automatic logic [DATA_W-1:0] rnd();
		logic [DATA_W-1:0] r;
		for (int j = 0; j < 8; j++) begin
			r[j*32+:32] = $urandom;
		end
		return r;
	endfunction : rnd
	task automatic reg_wr(input logic [31:0] a, input logic [31:0] v);
		rq <= '{1'b1, 1'b0, a, v};
		@(posedge sys_clk);
		rq.wr <= 1'b0;
		@(posedge sys_clk);
	endtask : reg_wr
	task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
		reg_q.push_back(exp);
		rq <= '{1'b0, 1'b1, a, WORD_ZERO};
		@(posedge sys_clk);
		rq.rd <= 1'b0;
		@(posedge sys_clk);
	endtask : reg_rd
	task automatic mem_w(input int l, input logic full, input logic emu, input logic [DATA_W-1:0] d);
		ln[l] = d;
		wr <= '{1'b1, full, emu, 1'b0, 1'b0, BASE + 32'(l * 32)};
		wdata <= d;
		@(posedge sys_clk);
		wr.valid <= 1'b0;
		@(posedge sys_clk);
	endtask : mem_w
	task automatic mem_r(input int l, input logic f, input logic ram, input logic fl, input logic full,
		input logic emu, input logic [1:0] exp);
		ev_q.push_back({30'h0, exp});
		rd <= '{1'b1, full, emu, f, ram, BASE + 32'(l * 32)};
		flip <= fl;
		@(posedge sys_clk);
		rd.valid <= 1'b0;
		flip <= 1'b0;
		@(posedge sys_clk);
	endtask : mem_r
	// watcher: read data and event pulses are looked at in the cycle after their request
	always @(negedge sys_clk) begin
		if (rd_pend) begin
			check(reg_rdata, (reg_q.size() > 0) ? reg_q.pop_front() : 32'hFFFF_FFFF);
		end
		if (mr_pend) begin
			check({30'h0, fexc, rev}, (ev_q.size() > 0) ? ev_q.pop_front() : 32'hFFFF_FFFF);
		end else if ({fexc, rev} !== 2'b00) begin
			check({30'h0, fexc, rev}, 32'h0);
		end
		rd_pend = rq.rd;
		mr_pend = rd.valid;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h29fc2992));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check({24'h0, ev_id}, 32'h71);
		reg_rd(ST, 32'h4);
		reg_rd(LC, 32'h0);
		reg_rd(CM, 32'h0);
		reg_rd(32'h0184_6400, 32'h0);
		for (i = 0; i < 4; i++) mem_w(i, 1'b1, 1'b0, rnd());
		reg_wr(CM, 32'h1);
		reg_rd(ST, 32'h1);
		mem_r(0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00);
		for (i = 0; i < 4; i++) mem_w(i, 1'b1, 1'b0, rnd());
		mem_r(0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'b00);
		mem_r(1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b10);
		reg_rd(ST, 32'h21);
		reg_rd(LC, BASE + 32'h21);
		mem_r(2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
		reg_wr(CM, 32'hFFFF_FF92);
		reg_rd(ST, 32'h21);
		reg_wr(CM, 32'h20);
		reg_rd(ST, 32'h1);
		mem_r(2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b01);
		reg_rd(LC, BASE + 32'h40);
		mem_r(3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b10);
		reg_rd(ST, 32'h21);
		reg_rd(LC, BASE + 32'h61);
		reg_wr(CM, 32'h61);
		reg_rd(ST, 32'h1);
		mem_w(0, 1'b0, 1'b0, rnd());
		mem_w(1, 1'b1, 1'b1, rnd());
		mem_r(0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00);
		mem_r(1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00);
		mem_r(2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'b00);
		mem_r(2, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
		reg_wr(CM, 32'h8);
		reg_rd(ST, 32'h8);
		mem_r(2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
		mem_w(2, 1'b1, 1'b0, ln[2] ^ 256'h1);
		mem_w(3, 1'b1, 1'b1, ln[3]);
		reg_wr(CM, 32'h1);
		mem_r(2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'b01);
		reg_wr(CM, 32'h41);
		mem_r(3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b10);
		reg_wr(CM, 32'h9);
		reg_rd(ST, 32'h24);
		reg_wr(CM, 32'h21);
		reg_wr(CM, 32'h4);
		mem_w(2, 1'b1, 1'b0, rnd());
		reg_wr(CM, 32'h1);
		mem_r(2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00);
		reg_rd(ST, 32'h1);
		repeat (3) @(posedge sys_clk);
		check(32'(reg_q.size() + ev_q.size()), 32'h0);
		end_of_test();
	end
endmodule : pmpc_top_tb
